// ---- otplk_pkg.sv ----
package otplk_pkg;

	// ********************************************************************
	// Geometry of the one-time-programmable space.
	// ********************************************************************
	localparam int          OTP_BYTES      = 1024;
	localparam int          REGION_BYTES   = 32;
	localparam int          REGION_COUNT   = 32;
	localparam int          RANDOM_BYTES   = 16;
	localparam logic [9:0]  RANDOM_END     = 10'h010;
	localparam logic [9:0]  LOCK_FIRST     = 10'h010;
	localparam logic [9:0]  RESERVED_FIRST = 10'h014;
	localparam logic [7:0]  ERASED_BYTE    = 8'hFF;

	// ********************************************************************
	// Register field positions and volatile reset values.
	// ********************************************************************
	localparam int          PERR_BIT             = 6;
	localparam int          FREEZE_BIT           = 0;
	localparam logic [7:0]  FREEZE_MASK          = 8'h01;
	localparam logic [7:0]  LOCK_RO_MASK         = 8'h01;
	localparam logic [7:0]  CONFIG_ONE_RESET     = 8'h00;
	localparam logic [7:0]  STATUS_TWO_VALUE     = 8'h00;
	localparam logic [7:0]  BANK_HIGH_RESET      = 8'h00;
	localparam logic [7:0]  ECC_STATUS_VALUE     = 8'h00;
	localparam logic [7:0]  PROTECT_LOCK_RESET   = 8'h00;
	localparam logic [7:0]  DYNAMIC_ACCESS_RESET = 8'h00;
	localparam logic [7:0]  WORKING_TRAIN_RESET  = 8'h00;

	// ********************************************************************
	// Factory delivery values of the non-volatile registers.
	// ********************************************************************
	localparam logic [31:0] BOOT_SETUP_FACTORY   = 32'h0000_0000;
	localparam logic [15:0] PROTECT_MODE_FACTORY = 16'hFFFF;
	localparam logic [63:0] PASSCODE_FACTORY     = 64'hFFFF_FFFF_FFFF_FFFF;
	localparam logic [7:0]  PERSIST_ACCESS_FACT  = 8'hFF;
	localparam logic [7:0]  STORED_TRAIN_FACTORY = 8'h00;

	// ********************************************************************
	// Commands, register selectors and the carriers.
	// ********************************************************************
	typedef enum logic [2:0] {
		OP_OTP_READ,
		OP_OTP_PROGRAM,
		OP_REG_READ,
		OP_REG_WRITE,
		OP_CLEAR_STATUS
	} otplk_op_t;

	typedef enum logic [3:0] {
		REG_STATUS_ONE,
		REG_CONFIG_ONE,
		REG_STATUS_TWO,
		REG_BOOT_READ_SETUP,
		REG_BANK_HIGH_ADDRESS,
		REG_ERROR_CORRECTION_STATUS,
		REG_SECTOR_PROTECT_MODE,
		REG_PROTECTION_PASSCODE,
		REG_PERSISTENT_PROTECT_LOCK,
		REG_PERSISTENT_PROTECT_ACCESS,
		REG_DYNAMIC_PROTECT_ACCESS,
		REG_STORED_TRAINING_PATTERN,
		REG_WORKING_TRAINING_PATTERN
	} otplk_reg_t;

	typedef struct packed {
		otplk_op_t   op;
		otplk_reg_t  reg_sel;
		logic [9:0]  addr;
		logic [63:0] wdata;
	} otplk_cmd_t;

	typedef struct packed {
		logic [63:0] data;
		logic        refused;
	} otplk_rsp_t;

endpackage

// ---- otplk_store.sv ----
`timescale 1ns/10ps

module otplk_store import otplk_pkg::*; (
	// Clock and the reset used by the checks.
	input  wire logic         clock,
	input  wire logic         rst,
	// Factory delivery.
	input  wire logic         factory_load,
	input  wire logic [127:0] factory_random,
	// Program port.
	input  wire logic         prog_en,
	input  wire logic [9:0]   prog_addr,
	input  wire logic [7:0]   prog_data,
	// Read port and lock view.
	input  wire logic [9:0]   rd_addr,
	output logic      [7:0]   rd_data,
	output logic      [31:0]  lock_bits
);

	// ********************************************************************
	// Cell array.
	// ********************************************************************
	logic [7:0] cell_ff [OTP_BYTES];

	// Cells carry no reset, so their contents survive every reset.
	always_ff @(posedge clock) begin
		if (factory_load) begin
			for (int i = 0; i < OTP_BYTES; i++) begin
				cell_ff[i] <= ERASED_BYTE;
			end
			for (int i = 0; i < RANDOM_BYTES; i++) begin
				cell_ff[i] <= factory_random[i*8 +: 8];
			end
		end else if (prog_en) begin
			cell_ff[prog_addr] <= cell_ff[prog_addr] & prog_data;
		end
	end

	// Read data and the four lock bytes, lowest byte guarding region 0.
	assign rd_data   = cell_ff[rd_addr];
	assign lock_bits = {cell_ff[LOCK_FIRST + 10'd3], cell_ff[LOCK_FIRST + 10'd2],
		cell_ff[LOCK_FIRST + 10'd1], cell_ff[LOCK_FIRST]};

	// ********************************************************************
	// Checks.
	// ********************************************************************
	a_program_clears_only: assert property (@(posedge clock) disable iff (rst)
		prog_en && !factory_load |=>
		cell_ff[$past(prog_addr)] == ($past(rd_data) & $past(prog_data)) ||
		$past(rd_addr) != $past(prog_addr))
		else $error("Program did not AND data into the cell.");

	a_lock_permanent: assert property (@(posedge clock) disable iff (rst)
		!factory_load |=> (lock_bits & ~$past(lock_bits)) == 32'h0000_0000)
		else $error("A lock bit returned to one.");

endmodule

// ---- otplk_core.sv ----
`timescale 1ns/10ps


module otplk_core import otplk_pkg::*; (
	// Clock and reset.
	input  wire logic         clock,
	input  wire logic         rst,
	// Factory delivery.
	input  wire logic         factory_load,
	input  wire logic [127:0] factory_random,
	// Command channel.
	input  wire logic         cmd_valid,
	input  wire otplk_cmd_t   cmd,
	output logic              cmd_ready,
	// Answer channel.
	output logic              rsp_valid,
	output otplk_rsp_t        rsp,
	// Live protection state.
	output logic              freeze_active
);

	// ********************************************************************
	// Helpers.
	// ********************************************************************

	// Region number of a byte address in the one-time space.
	function automatic logic [4:0] region_of(input logic [9:0] addr);
		return addr[9:5];
	endfunction

	// ********************************************************************
	// Declarations.
	// ********************************************************************
	logic        take;
	logic        is_otp_read;
	logic        is_prog;
	logic        is_reg_read;
	logic        is_wr;
	logic        is_clear;
	logic [31:0] lock_bits;
	logic [7:0]  otp_byte;
	logic        region_locked;
	logic        in_random;
	logic        prog_block;
	logic        prog_go;
	logic        prog_err;
	logic        wr_refused;
	logic        reg_known;
	logic [63:0] reg_rdata;
	logic [63:0] nxt_rdata;
	otplk_rsp_t  rsp_ff;
	logic        rsp_valid_ff;

	// Volatile registers.
	logic        p_err_ff;
	logic [7:0]  config_one_ff;
	logic [7:0]  bank_high_ff;
	logic [7:0]  protect_lock_ff;
	logic [7:0]  dynamic_access_ff;
	logic [7:0]  working_train_ff;
	logic        nxt_p_err;
	logic [7:0]  nxt_config_one;
	logic [7:0]  nxt_bank_high;
	logic [7:0]  nxt_protect_lock;
	logic [7:0]  nxt_dynamic_access;
	logic [7:0]  nxt_working_train;

	// Non-volatile and one-time registers.
	logic [31:0] boot_setup_ff;
	logic [15:0] protect_mode_ff;
	logic [63:0] passcode_ff;
	logic [7:0]  persist_access_ff;
	logic [7:0]  stored_train_ff;
	logic [31:0] nxt_boot_setup;
	logic [15:0] nxt_protect_mode;
	logic [63:0] nxt_passcode;
	logic [7:0]  nxt_persist_access;
	logic [7:0]  nxt_stored_train;

	// ********************************************************************
	// Command decode.
	// ********************************************************************

	// Commands are refused while reset or factory delivery is under way.
	assign cmd_ready   = !rst && !factory_load;
	assign take        = cmd_valid && cmd_ready;
	assign is_otp_read = take && (cmd.op == OP_OTP_READ);
	assign is_prog     = take && (cmd.op == OP_OTP_PROGRAM);
	assign is_reg_read = take && (cmd.op == OP_REG_READ);
	assign is_wr       = take && (cmd.op == OP_REG_WRITE);
	assign is_clear    = take && (cmd.op == OP_CLEAR_STATUS);

	// ********************************************************************
	// One-time space and its protection.
	// ********************************************************************
	otplk_store u_store (
		.clock          (clock),
		.rst            (rst),
		.factory_load   (factory_load),
		.factory_random (factory_random),
		.prog_en        (prog_go),
		.prog_addr      (cmd.addr),
		.prog_data      (cmd.wdata[7:0]),
		.rd_addr        (cmd.addr),
		.rd_data        (otp_byte),
		.lock_bits      (lock_bits)
	);

	// Any one of freeze, a clear lock bit or the random field blocks a program.
	assign region_locked = !lock_bits[region_of(cmd.addr)];
	assign in_random     = cmd.addr < RANDOM_END;
	assign prog_block    = config_one_ff[FREEZE_BIT] || region_locked || in_random;
	assign prog_go       = is_prog && !prog_block;
	assign prog_err      = is_prog && prog_block;

	// ********************************************************************
	// Register writes.
	// ********************************************************************

	// Whole read-only registers and unknown selectors refuse a write.
	assign reg_known  = cmd.reg_sel <= REG_WORKING_TRAINING_PATTERN;
	assign wr_refused = is_wr && (!reg_known || cmd.reg_sel == REG_STATUS_ONE ||
		cmd.reg_sel == REG_STATUS_TWO || cmd.reg_sel == REG_ERROR_CORRECTION_STATUS);

	// Error flag: a new error wins over a clear in the same cycle.
	assign nxt_p_err = prog_err || (p_err_ff && !is_clear);

	// The freeze bit is ORed back in, so a write can never lower it.
	assign nxt_config_one = (is_wr && cmd.reg_sel == REG_CONFIG_ONE) ?
		(cmd.wdata[7:0] | (config_one_ff & FREEZE_MASK)) : config_one_ff;
	assign nxt_bank_high = (is_wr && cmd.reg_sel == REG_BANK_HIGH_ADDRESS) ?
		cmd.wdata[7:0] : bank_high_ff;
	assign nxt_protect_lock = (is_wr && cmd.reg_sel == REG_PERSISTENT_PROTECT_LOCK) ?
		((cmd.wdata[7:0] & ~LOCK_RO_MASK) | (protect_lock_ff & LOCK_RO_MASK)) :
		protect_lock_ff;
	assign nxt_dynamic_access = (is_wr && cmd.reg_sel == REG_DYNAMIC_PROTECT_ACCESS) ?
		cmd.wdata[7:0] : dynamic_access_ff;
	assign nxt_working_train = (is_wr && cmd.reg_sel == REG_WORKING_TRAINING_PATTERN) ?
		cmd.wdata[7:0] : working_train_ff;

	// Non-volatile next values; the protect mode bits only ever clear.
	assign nxt_boot_setup = (is_wr && cmd.reg_sel == REG_BOOT_READ_SETUP) ?
		cmd.wdata[31:0] : boot_setup_ff;
	assign nxt_protect_mode = (is_wr && cmd.reg_sel == REG_SECTOR_PROTECT_MODE) ?
		(protect_mode_ff & {cmd.wdata[15:1], 1'b1}) : protect_mode_ff;
	assign nxt_passcode = (is_wr && cmd.reg_sel == REG_PROTECTION_PASSCODE) ?
		cmd.wdata : passcode_ff;
	assign nxt_persist_access = (is_wr && cmd.reg_sel == REG_PERSISTENT_PROTECT_ACCESS) ?
		cmd.wdata[7:0] : persist_access_ff;
	assign nxt_stored_train = (is_wr && cmd.reg_sel == REG_STORED_TRAINING_PATTERN) ?
		cmd.wdata[7:0] : stored_train_ff;

	// Volatile registers return to their defaults on reset.
	always_ff @(posedge clock) begin
		if (rst) begin
			p_err_ff          <= 1'b0;
			config_one_ff     <= CONFIG_ONE_RESET;
			bank_high_ff      <= BANK_HIGH_RESET;
			protect_lock_ff   <= PROTECT_LOCK_RESET;
			dynamic_access_ff <= DYNAMIC_ACCESS_RESET;
			working_train_ff  <= WORKING_TRAIN_RESET;
		end else begin
			p_err_ff          <= nxt_p_err;
			config_one_ff     <= nxt_config_one;
			bank_high_ff      <= nxt_bank_high;
			protect_lock_ff   <= nxt_protect_lock;
			dynamic_access_ff <= nxt_dynamic_access;
			working_train_ff  <= nxt_working_train;
		end
	end

	// Non-volatile registers ignore reset and take factory values on delivery.
	always_ff @(posedge clock) begin
		if (factory_load) begin
			boot_setup_ff     <= BOOT_SETUP_FACTORY;
			protect_mode_ff   <= PROTECT_MODE_FACTORY;
			passcode_ff       <= PASSCODE_FACTORY;
			persist_access_ff <= PERSIST_ACCESS_FACT;
			stored_train_ff   <= STORED_TRAIN_FACTORY;
		end else begin
			boot_setup_ff     <= nxt_boot_setup;
			protect_mode_ff   <= nxt_protect_mode;
			passcode_ff       <= nxt_passcode;
			persist_access_ff <= nxt_persist_access;
			stored_train_ff   <= nxt_stored_train;
		end
	end

	// ********************************************************************
	// Register reads and the answer.
	// ********************************************************************

	// Read selection by register; unknown selectors read as zero.
	always_comb begin
		unique case (cmd.reg_sel)
			REG_STATUS_ONE:                reg_rdata = 64'(8'(p_err_ff) << PERR_BIT);
			REG_CONFIG_ONE:                reg_rdata = 64'(config_one_ff);
			REG_STATUS_TWO:                reg_rdata = 64'(STATUS_TWO_VALUE);
			REG_BOOT_READ_SETUP:           reg_rdata = 64'(boot_setup_ff);
			REG_BANK_HIGH_ADDRESS:         reg_rdata = 64'(bank_high_ff);
			REG_ERROR_CORRECTION_STATUS:   reg_rdata = 64'(ECC_STATUS_VALUE);
			REG_SECTOR_PROTECT_MODE:       reg_rdata = 64'(protect_mode_ff);
			REG_PROTECTION_PASSCODE:       reg_rdata = passcode_ff;
			REG_PERSISTENT_PROTECT_LOCK:   reg_rdata = 64'(protect_lock_ff);
			REG_PERSISTENT_PROTECT_ACCESS: reg_rdata = 64'(persist_access_ff);
			REG_DYNAMIC_PROTECT_ACCESS:    reg_rdata = 64'(dynamic_access_ff);
			REG_STORED_TRAINING_PATTERN:   reg_rdata = 64'(stored_train_ff);
			REG_WORKING_TRAINING_PATTERN:  reg_rdata = 64'(working_train_ff);
			default:                       reg_rdata = 64'h0000_0000_0000_0000;
		endcase
	end

	// Data carried back by the answer.
	assign nxt_rdata = is_otp_read ? 64'(otp_byte) :
		(is_reg_read ? reg_rdata : 64'h0000_0000_0000_0000);

	// The answer follows every taken command by one cycle.
	always_ff @(posedge clock) begin
		if (rst) begin
			rsp_valid_ff <= 1'b0;
			rsp_ff       <= '0;
		end else begin
			rsp_valid_ff <= take;
			rsp_ff       <= '{data: nxt_rdata, refused: prog_err || wr_refused};
		end
	end

	// Answer and freeze state leave straight from their flip-flops.
	assign rsp_valid     = rsp_valid_ff;
	assign rsp           = rsp_ff;
	assign freeze_active = config_one_ff[FREEZE_BIT];

	// ********************************************************************
	// Checks.
	// ********************************************************************

	a_freeze_stays_set: assert property (@(posedge clock) disable iff (rst)
		config_one_ff[FREEZE_BIT] |=> config_one_ff[FREEZE_BIT])
		else $error("Freeze bit dropped without reset.");

	a_freeze_blocks_prog: assert property (@(posedge clock) disable iff (rst)
		is_prog && config_one_ff[FREEZE_BIT] |=> rsp_valid && rsp.refused && p_err_ff)
		else $error("Program was not refused while frozen.");

	a_locked_sets_error: assert property (@(posedge clock) disable iff (rst)
		is_prog && !lock_bits[region_of(cmd.addr)] ##1 !is_clear |=>
		p_err_ff && $past(rsp.refused))
		else $error("Locked region program did not raise the error flag.");

	a_random_refused: assert property (@(posedge clock) disable iff (rst)
		is_prog && cmd.addr <= 10'h00F |-> !prog_go ##1 rsp.refused)
		else $error("Program reached the random number bytes.");

	a_open_prog_taken: assert property (@(posedge clock) disable iff (rst)
		is_prog && cmd.addr >= RESERVED_FIRST && lock_bits[region_of(cmd.addr)] &&
		!config_one_ff[FREEZE_BIT] |-> prog_go ##1 !rsp.refused)
		else $error("Open region program was refused.");

	a_answer_follows: assert property (@(posedge clock) disable iff (rst)
		take |=> rsp_valid ##1 (rsp_valid == $past(take)))
		else $error("Answer did not follow the command by one cycle.");

	a_reset_defaults: assert property (@(posedge clock) disable iff (rst)
		$fell(rst) |-> config_one_ff == CONFIG_ONE_RESET && !p_err_ff && !rsp_valid &&
		bank_high_ff == BANK_HIGH_RESET)
		else $error("Volatile register missed its default after reset.");

	a_nonvolatile_kept: assert property (@(posedge clock) disable iff (rst)
		$fell(rst) |-> boot_setup_ff == $past(boot_setup_ff, 2) &&
		passcode_ff == $past(passcode_ff, 2) || $past(factory_load, 2))
		else $error("Non-volatile register changed across reset.");

	a_error_clear_waits: assert property (@(posedge clock) disable iff (rst)
		p_err_ff && !is_clear |=> p_err_ff)
		else $error("Error flag cleared without a clear command.");

	a_prog_error_set: assert property (@(posedge clock) disable iff (rst)
		prog_err |=> p_err_ff)
		else $error("Refused program did not raise the error flag.");

	a_clear_drops_error: assert property (@(posedge clock) disable iff (rst)
		is_clear |=> !p_err_ff)
		else $error("Clear command left the error flag set.");

	a_volatile_reset: assert property (@(posedge clock)
		rst |=> !p_err_ff && !rsp_valid && config_one_ff == CONFIG_ONE_RESET &&
		protect_lock_ff == PROTECT_LOCK_RESET &&
		working_train_ff == WORKING_TRAIN_RESET &&
		dynamic_access_ff == DYNAMIC_ACCESS_RESET)
		else $error("Volatile register missed its default during reset.");

	a_write_refused_kept: assert property (@(posedge clock) disable iff (rst)
		wr_refused |=> rsp.refused && p_err_ff == $past(p_err_ff))
		else $error("Refused register write was not reported or touched the status.");

	a_protect_mode_clears: assert property (@(posedge clock) disable iff (rst)
		!factory_load |=> (protect_mode_ff & ~$past(protect_mode_ff)) == 16'h0000)
		else $error("A protect mode bit returned to one.");

	a_idle_no_answer: assert property (@(posedge clock) disable iff (rst)
		!take |=> !rsp_valid)
		else $error("Answer appeared without a taken command.");

	a_write_no_data: assert property (@(posedge clock) disable iff (rst)
		is_prog || is_wr || is_clear |=> rsp.data == 64'h0000_0000_0000_0000)
		else $error("Non-read command answered with data.");

	a_config_read_back: assert property (@(posedge clock) disable iff (rst)
		is_reg_read && cmd.reg_sel == REG_CONFIG_ONE |=>
		rsp.data == 64'($past(config_one_ff)))
		else $error("Config register read returned the wrong value.");

	a_otp_read_data: assert property (@(posedge clock) disable iff (rst)
		is_otp_read |=> rsp.data == 64'($past(otp_byte)) && !rsp.refused)
		else $error("Space read returned the wrong byte.");

	// ********************************************************************
	// Coverage.
	// ********************************************************************

	// Main scenarios that the bench is expected to reach.
	c_program_accepted: cover property (@(posedge clock) disable iff (rst)
		prog_go ##2 is_otp_read);
	c_locked_refused: cover property (@(posedge clock) disable iff (rst)
		is_prog && region_locked);
	c_freeze_set: cover property (@(posedge clock) disable iff (rst)
		$rose(config_one_ff[FREEZE_BIT]));
	c_register_read: cover property (@(posedge clock) disable iff (rst)
		is_reg_read && cmd.reg_sel == REG_SECTOR_PROTECT_MODE);
	c_freeze_refused: cover property (@(posedge clock) disable iff (rst)
		is_prog && config_one_ff[FREEZE_BIT]);

endmodule

// ---- otplk_host.sv ----
`timescale 1ns/10ps

// ********************************************************************
// Host controller model that issues one command at a time.
// ********************************************************************
module otplk_host import otplk_pkg::*; (
	// Clock.
	input  wire logic       clock,
	// Command channel toward the device.
	output logic            cmd_valid,
	output otplk_cmd_t      cmd,
	input  wire logic       cmd_ready,
	// Answer channel from the device.
	input  wire logic       rsp_valid,
	input  wire otplk_rsp_t rsp
);
	// The channel starts idle.
	initial begin
		cmd_valid = 1'b0;
		cmd       = '0;
	end

	// Holds the request from a falling edge until the falling edge after the rising edge that takes it.
	// After release the command lines are inverted so stale values are never trusted.
	task automatic issue(input otplk_op_t op, input otplk_reg_t sel, input logic [9:0] a,
		input logic [63:0] wd, output otplk_rsp_t r, output logic ok);
		int n;
		ok = 1'b0;
		r  = '0;
		@(negedge clock);
		cmd_valid = 1'b1;
		cmd       = '{op: op, reg_sel: sel, addr: a, wdata: wd};
		for (n = 0; n < 20 && !ok; n++) begin
			@(posedge clock);
			ok = cmd_ready;
		end
		@(negedge clock);
		cmd_valid = 1'b0;
		cmd       = ~cmd;
		if (ok && rsp_valid === 1'b1) begin
			r = rsp;
		end else begin
			ok = 1'b0;
		end
	endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/10ps

module testbench import otplk_pkg::*;;
	// Arbitrary factory random number and the error flag as read back.
	localparam logic [127:0] RAND     = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0;
	localparam logic [7:0]   PERR_SET = 8'h01 << PERR_BIT;

	logic        clock;
	logic        rst;
	logic        factory_load;
	logic        cmd_valid;
	logic        cmd_ready;
	logic        rsp_valid;
	logic        freeze_active;
	otplk_cmd_t  cmd;
	otplk_rsp_t  rsp;
	otplk_rsp_t  r;
	logic        ok;
	int          fails;
	int          tests_run;

	// The clock toggles every half period of 25 ns.
	always #25 clock = ~clock;

	// Device under test and the host model.
	otplk_core i_otplk_core (
		.clock          (clock),
		.rst            (rst),
		.factory_load   (factory_load),
		.factory_random (RAND),
		.cmd_valid      (cmd_valid),
		.cmd            (cmd),
		.cmd_ready      (cmd_ready),
		.rsp_valid      (rsp_valid),
		.rsp            (rsp),
		.freeze_active  (freeze_active)
	);
	otplk_host i_otplk_host (
		.clock     (clock),
		.cmd_valid (cmd_valid),
		.cmd       (cmd),
		.cmd_ready (cmd_ready),
		.rsp_valid (rsp_valid),
		.rsp       (rsp)
	);

	// ********************************************************************
	// Shared tasks.
	// ********************************************************************
	// Compares one value and counts the outcome.
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Issues one command; a missing answer ends the run.
	task automatic run(input otplk_op_t op, input otplk_reg_t sel, input logic [9:0] a,
		input logic [63:0] wd);
		i_otplk_host.issue(op, sel, a, wd, r, ok);
		if (!ok) begin
			fails++;
			$display("BAD at %0t: command not answered", $time);
			end_of_test();
		end
	endtask

	// Reads one byte of the space and compares it.
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		run(OP_OTP_READ, REG_STATUS_ONE, a, 64'h0);
		check(r.data, {56'h0, e});
	endtask

	// Programs one byte and compares the refusal flag.
	task automatic prg(input logic [9:0] a, input logic [7:0] d, input logic refused);
		run(OP_OTP_PROGRAM, REG_STATUS_ONE, a, {56'h0, d});
		check(64'(r.refused), 64'(refused));
	endtask

	// Reads one register and compares it.
	task automatic rg(input otplk_reg_t sel, input logic [63:0] e);
		run(OP_REG_READ, sel, 10'h000, 64'h0);
		check(r.data, e);
	endtask

	// Writes one register and compares the refusal flag.
	task automatic wr(input otplk_reg_t sel, input logic [63:0] d, input logic refused);
		run(OP_REG_WRITE, sel, 10'h000, d);
		check(64'(r.refused), 64'(refused));
	endtask

	// Holds reset for six cycles.
	task automatic do_reset();
		@(negedge clock);
		rst = 1'b1;
		repeat (6) @(negedge clock);
		rst = 1'b0;
	endtask

	// ********************************************************************
	// Scenarios.
	// ********************************************************************
	// Delivery contents: random number, erased lock and reserved bytes, erased regions.
	task automatic t_delivery();
		for (int i = 0; i < RANDOM_BYTES; i++)
			rd(10'(i), RAND[8*i +: 8]);
		for (int i = 16; i < 32; i++)
			rd(10'(i), ERASED_BYTE);
		for (int i = 1; i < REGION_COUNT; i++) begin
			rd(10'(i * REGION_BYTES), ERASED_BYTE);
			rd(10'(i * REGION_BYTES + 31), ERASED_BYTE);
		end
	endtask

	// A program into the random number is refused and flags an error until cleared.
	task automatic t_random();
		prg(10'h005, 8'h00, 1'b1);
		rd(10'h005, RAND[47:40]);
		rg(REG_STATUS_ONE, 64'(PERR_SET));
		run(OP_CLEAR_STATUS, REG_STATUS_ONE, 10'h000, 64'h0);
		rg(REG_STATUS_ONE, 64'h0);
	endtask

	// Programs only clear bits, at the last byte and in the reserved bytes too.
	task automatic t_program();
		prg(10'h020, 8'h0F, 1'b0);
		rd(10'h020, 8'h0F);
		prg(10'h020, 8'hF0, 1'b0);
		rd(10'h020, 8'h00);
		prg(10'h3FF, 8'hA5, 1'b0);
		prg(10'h3FF, 8'hFF, 1'b0);
		rd(10'h3FF, 8'hA5);
		prg(10'h01F, 8'h3C, 1'b0);
		rd(10'h01F, 8'h3C);
		rg(REG_STATUS_ONE, 64'h0);
	endtask

	// Defaults, kinds of access, and what survives a reset.
	task automatic t_registers();
		logic [63:0] dflt [13];
		dflt = '{64'h0, 64'(CONFIG_ONE_RESET), 64'(STATUS_TWO_VALUE),
			64'(BOOT_SETUP_FACTORY), 64'(BANK_HIGH_RESET), 64'(ECC_STATUS_VALUE),
			64'(PROTECT_MODE_FACTORY), PASSCODE_FACTORY, 64'(PROTECT_LOCK_RESET),
			64'(PERSIST_ACCESS_FACT), 64'(DYNAMIC_ACCESS_RESET),
			64'(STORED_TRAIN_FACTORY), 64'(WORKING_TRAIN_RESET)};
		for (int i = 0; i < 13; i++)
			rg(otplk_reg_t'(i), dflt[i]);
		wr(REG_BANK_HIGH_ADDRESS, 64'h5A, 1'b0);
		wr(REG_BOOT_READ_SETUP, 64'h1234_5678, 1'b0);
		wr(REG_STATUS_ONE, 64'hFF, 1'b1);
		wr(otplk_reg_t'(4'hD), 64'h1, 1'b1);
		wr(REG_SECTOR_PROTECT_MODE, 64'h0F0F, 1'b0);
		wr(REG_SECTOR_PROTECT_MODE, 64'hFFFF, 1'b0);
		wr(REG_PERSISTENT_PROTECT_LOCK, 64'hFF, 1'b0);
		rg(REG_SECTOR_PROTECT_MODE, 64'h0F0F);
		rg(REG_PERSISTENT_PROTECT_LOCK, 64'hFE);
		rg(REG_BANK_HIGH_ADDRESS, 64'h5A);
		rg(REG_STATUS_ONE, 64'h0);
		do_reset();
		rg(REG_BANK_HIGH_ADDRESS, 64'(BANK_HIGH_RESET));
		rg(REG_BOOT_READ_SETUP, 64'h1234_5678);
		rg(REG_PERSISTENT_PROTECT_LOCK, 64'(PROTECT_LOCK_RESET));
		rg(REG_SECTOR_PROTECT_MODE, 64'h0F0F);
	endtask

	// Lock bits guard their own regions and stay in force after reset.
	task automatic t_lock();
		prg(LOCK_FIRST, 8'hFD, 1'b0);
		prg(10'h021, 8'h00, 1'b1);
		rd(10'h021, ERASED_BYTE);
		rg(REG_STATUS_ONE, 64'(PERR_SET));
		run(OP_CLEAR_STATUS, REG_STATUS_ONE, 10'h000, 64'h0);
		prg(10'h040, 8'h11, 1'b0);
		prg(10'h013, 8'h7F, 1'b0);
		prg(10'h3E0, 8'h00, 1'b1);
		prg(10'h3DF, 8'h00, 1'b0);
		do_reset();
		prg(10'h03F, 8'h00, 1'b1);
		rd(LOCK_FIRST, 8'hFD);
	endtask

	// Boot code sets the freeze bit, which blocks all programs until reset.
	task automatic t_freeze();
		check(64'(freeze_active), 64'h0);
		wr(REG_CONFIG_ONE, 64'(FREEZE_MASK), 1'b0);
		check(64'(freeze_active), 64'h1);
		prg(10'h060, 8'h00, 1'b1);
		rd(10'h060, ERASED_BYTE);
		run(OP_REG_WRITE, REG_CONFIG_ONE, 10'h000, 64'h0);
		rg(REG_CONFIG_ONE, 64'(FREEZE_MASK));
		prg(10'h061, 8'h00, 1'b1);
		do_reset();
		rg(REG_CONFIG_ONE, 64'(CONFIG_ONE_RESET));
		prg(10'h060, 8'h55, 1'b0);
		rd(10'h060, 8'h55);
	endtask

	// ********************************************************************
	// Main sequence.
	// ********************************************************************
	// Factory delivery happens inside the six reset cycles.
	initial begin
		clock        = 1'b0;
		rst          = 1'b1;
		factory_load = 1'b0;
		fails        = 0;
		tests_run    = 0;
		repeat (2) @(negedge clock);
		factory_load = 1'b1;
		repeat (2) @(negedge clock);
		factory_load = 1'b0;
		repeat (2) @(negedge clock);
		rst = 1'b0;
		t_delivery();
		t_random();
		t_program();
		t_registers();
		t_lock();
		t_freeze();
		end_of_test();
	end
endmodule
